// ===== hdl/cal_lock_consts.svh
// Constants for the calibration lock, the entry editor and the calibration counter.
// Assumes nothing; included by bare name wherever a constant is needed.
`ifndef CAL_LOCK_CONSTS_SVH
`define CAL_LOCK_CONSTS_SVH
`define CODE_MAX_LEN    12
`define CODE_LEN_W      4
`define FP_CODE_LEN     4'h8
`define FP_DIGITS       6
`define FP_PREFIX_LEN   2
`define MSG_LEN         40
`define MSG_IDX_W       6
`define CHAR_ZERO       8'h30
`define CHAR_NINE       8'h39
`define CHAR_UP_A       8'h41
`define CHAR_UP_Z       8'h5A
`define CHAR_LO_A       8'h61
`define CHAR_LO_Z       8'h7A
`define DIGIT_MAX       4'h9
// Factory code value is arbitrary; a fixed two-letter prefix then six digits.
`define FACTORY_CODE    64'h5859_3030_3030_3031
`define COUNT_W         15
`define COUNT_MAX       15'h7FFF
`define CLK_PERIOD_NS   4
`define HOLD_TIME_NS    1000000000
`define HOLD_CYCLES     (`HOLD_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== hdl/cal_lock_pkg.sv
// Types shared by the calibration lock and its testbench.
// Assumes nothing of its surroundings.
package cal_lock_pkg;
  typedef enum logic [2:0] {
    DISP_NORMAL    = 3'b000,
    DISP_SECURED   = 3'b001,
    DISP_BANNER    = 3'b010,
    DISP_CODE      = 3'b011,
    DISP_UNSECURED = 3'b100
  } disp_t;
  typedef enum logic [1:0] {
    OP_UNSECURE = 2'b00,
    OP_SECURE   = 2'b01,
    OP_SET_CODE = 2'b10,
    OP_NONE     = 2'b11
  } rem_op_t;
endpackage : cal_lock_pkg

// ===== hdl/code_entry.sv
// Front-panel code editor: six decimal digits, a cursor and a knob.
// Assumes one-cycle key and knob pulses synchronous to clk.
`timescale 1ns/1ns
`include "cal_lock_consts.svh"
module code_entry #(
  parameter int unsigned DIGITS = `FP_DIGITS
) (
  input  wire logic                   clk,       // System clock.
  input  wire logic                   srst,      // Synchronous reset.
  input  wire logic                   ce,        // Clock enable.
  input  wire logic                   start,     // Clear digits and home the cursor.
  input  wire logic                   active,    // Editing allowed.
  input  wire logic                   res_left,  // Move cursor left.
  input  wire logic                   res_right, // Move cursor right.
  input  wire logic                   knob_up,   // Increment digit at cursor.
  input  wire logic                   knob_down, // Decrement digit at cursor.
  output logic [DIGITS*4-1:0]         digits,    // Digit 0 (leftmost) in the top nibble.
  output logic [$clog2(DIGITS)-1:0]   cursor     // Cursor position, 0 is leftmost.
);
  localparam int unsigned CW = $clog2(DIGITS);
  localparam logic [CW-1:0] LAST = CW'(DIGITS - 1);
  logic [DIGITS*4-1:0] digits_reg, digits_next;
  logic [CW-1:0]       cursor_reg, cursor_next;
  logic [3:0]          cur_digit;
  int unsigned         pos;

  // Resolution keys move the cursor; the knob rolls the digit under it, wrapping through 0 and 9.
  always_comb begin
    digits_next = digits_reg;
    cursor_next = cursor_reg;
    pos         = (DIGITS - 1 - int'(cursor_reg)) * 4;
    cur_digit   = digits_reg[pos +: 4];
    if (start) begin
      digits_next = '0;
      cursor_next = '0;
    end else if (active) begin
      if (res_left && cursor_reg != '0)
        cursor_next = cursor_reg - 1'b1;
      else if (res_right && cursor_reg != LAST)
        cursor_next = cursor_reg + 1'b1;
      if (knob_up)
        digits_next[pos +: 4] = (cur_digit == `DIGIT_MAX) ? 4'h0 : cur_digit + 4'h1;
      else if (knob_down)
        digits_next[pos +: 4] = (cur_digit == 4'h0) ? `DIGIT_MAX : cur_digit - 4'h1;
    end
  end

  // Register the editor state.
  always_ff @(posedge clk) begin
    if (srst) begin
      digits_reg <= '0;
      cursor_reg <= '0;
    end else if (ce) begin
      digits_reg <= digits_next;
      cursor_reg <= cursor_next;
    end
  end

  assign digits = digits_reg;
  assign cursor = cursor_reg;

  a_knob_wraps: assert property (@(posedge clk) disable iff (srst)
    ce && active && !start && knob_up && cursor_reg == '0 && digits_reg[DIGITS*4-1 -: 4] == `DIGIT_MAX
    |=> digits_reg[DIGITS*4-1 -: 4] == 4'h0)
    else $error("Digit did not wrap from nine to zero.");
endmodule : code_entry

// ===== hdl/cal_counter.sv
// Non-volatile calibration counter: counts stored parameters and wraps at its top.
// Assumes the storage keeps its value through srst; only the factory load sets it.
`timescale 1ns/1ns
`include "cal_lock_consts.svh"
module cal_counter #(
  parameter int unsigned WIDTH = `COUNT_W
) (
  input  wire logic             clk,          // System clock.
  input  wire logic             srst,         // Synchronous reset, does not touch the count.
  input  wire logic             ce,           // Clock enable.
  input  wire logic             factory_load, // Factory initialisation of storage.
  input  wire logic             inc,          // One stored calibration parameter.
  output logic [WIDTH-1:0]      count         // Read-only count.
);
  logic [WIDTH-1:0] count_reg, count_next;

  // Add one per parameter; the all-ones top rolls over to zero. No write path exists.
  always_comb begin
    count_next = count_reg;
    if (factory_load)
      count_next = '0;
    else if (inc)
      count_next = (count_reg == WIDTH'(`COUNT_MAX)) ? '0 : count_reg + 1'b1;
  end

  // Storage survives reset, standing in for non-volatile memory.
  always_ff @(posedge clk) begin
    if (ce)
      count_reg <= count_next;
  end

  assign count = count_reg;

  a_count_wrap: assert property (@(posedge clk) disable iff (srst)
    ce && inc && !factory_load && count_reg == WIDTH'(`COUNT_MAX) |=> count_reg == '0)
    else $error("Counter did not wrap to zero.");
  a_count_step: assert property (@(posedge clk) disable iff (srst)
    ce && inc && !factory_load && count_reg != WIDTH'(`COUNT_MAX) |=> count_reg == $past(count_reg) + 1'b1)
    else $error("Counter did not add one.");
  a_count_hold: assert property (@(posedge clk) disable iff (srst)
    !factory_load && !inc |=> $stable(count_reg))
    else $error("Counter changed without a stored parameter.");
  c_count_wrap: cover property (@(posedge clk) ce && inc && count_reg == WIDTH'(`COUNT_MAX));
endmodule : cal_counter

// ===== hdl/calibration_lock_and_counter.sv
// Calibration access control: code storage, secure state, calibration mode, message store.
// Assumes srst marks power-up, every key input but the held calibrate key is a one-cycle pulse, and inputs are synchronous to clk.
`timescale 1ns/1ns
`include "cal_lock_consts.svh"
// How it works
// - Factory load leaves the device secured until a correct code arrives.
// - Calibration stores are refused while secured; host must unsecure first.
// - Stored code sits in storage untouched by reset or remote interface reset.
// - Remote codes hold 1 to 12 letters or digits, first a letter.
// - Front-panel usable codes are eight characters: prefix then digits.
// - Front-panel entry is checked against the last six stored characters only.
// - Resolution keys move the cursor; the knob changes the digit there.
// - Calibration mode starts only if calibrate is held at power-up; long beep.
// - Secured entry shows the secured notice one second, then the banner.
// - Correct code plus secure key unsecures, notice one second, then banner.
// - Calibration mode ends only by power-off.
// - Same sequence while unsecured secures the device again.
// - With the override jumper shorted any entered code unsecures.
// - An error stands while the jumper stays shorted after override.
// - Counter adds one per stored calibration parameter.
// - Counter wraps from 32767 to 0.
// - Counter cannot be written from outside and is cleared only by the factory load.
// - Counter is kept in storage and readable.
// - Host can secure, unsecure, change code and store or read a 40-char message.
module calibration_lock_and_counter #(
  parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES
) (
  input  wire logic                       clk,                 // System clock, 250 MHz.
  input  wire logic                       srst,                // Synchronous reset, power-up.
  input  wire logic                       ce,                  // Clock enable.
  input  wire logic                       factory_load,        // Factory initialisation of storage.
  input  wire logic                       cal_key_held,        // Calibrate key held down.
  input  wire logic                       secure_key,          // Secure key pulse.
  input  wire logic                       res_left,            // Cursor left pulse.
  input  wire logic                       res_right,           // Cursor right pulse.
  input  wire logic                       knob_up,             // Knob step up pulse.
  input  wire logic                       knob_down,           // Knob step down pulse.
  input  wire logic                       override_jumper,     // Override pads shorted.
  input  wire logic                       override_jumper_alt, // Alternate override pads shorted.
  input  wire logic                       cal_param_store,     // Request to store one parameter.
  input  wire logic                       rem_if_reset,        // Remote interface reset.
  input  wire logic                       rem_valid,           // Remote command strobe.
  input  cal_lock_pkg::rem_op_t           rem_op,              // Remote command.
  input  wire logic [`CODE_MAX_LEN*8-1:0] rem_code,            // Code, character 0 in low byte.
  input  wire logic [`CODE_LEN_W-1:0]     rem_code_len,        // Code length in characters.
  input  wire logic                       rem_msg_we,          // Message character write.
  input  wire logic [`MSG_IDX_W-1:0]      rem_msg_idx,         // Message write index.
  input  wire logic [7:0]                 rem_msg_char,        // Message write character.
  input  wire logic [`MSG_IDX_W-1:0]      rem_msg_ridx,        // Message read index.
  output logic                            cal_mode,            // In calibration mode.
  output logic                            secured,             // Device secured.
  output cal_lock_pkg::disp_t             disp,                // Display content.
  output logic                            beep_long,           // Long beep pulse.
  output logic [`FP_DIGITS*4-1:0]         entry_digits,        // Digits being entered.
  output logic [2:0]                      entry_cursor,        // Cursor position.
  output logic [`COUNT_W-1:0]             cal_count,           // Calibration count.
  output logic                            cal_accepted,        // Parameter store accepted pulse.
  output logic                            cal_refused,         // Parameter store refused pulse.
  output logic                            entry_error,         // Wrong front-panel code pulse.
  output logic                            jumper_error,        // Jumper left shorted.
  output logic                            rem_ack,             // Remote command done pulse.
  output logic                            rem_err,             // Remote command refused pulse.
  output logic [7:0]                      rem_msg_rdata        // Message read character.
);
  import cal_lock_pkg::*;
  localparam int unsigned TW = $clog2(HOLD_CYCLES + 1);
  // Factory code as a named constant, so that single characters can be picked out of it.
  localparam logic [`FP_CODE_LEN*8-1:0] FACTORY = `FACTORY_CODE;

  // Character class checks used by several comparisons.
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= `CHAR_ZERO) && (c <= `CHAR_NINE);
  endfunction : is_digit
  function automatic logic is_letter(input logic [7:0] c);
    is_letter = ((c >= `CHAR_UP_A) && (c <= `CHAR_UP_Z)) || ((c >= `CHAR_LO_A) && (c <= `CHAR_LO_Z));
  endfunction : is_letter

  logic [7:0]            code_mem [`CODE_MAX_LEN];
  logic [7:0]            code_mem_next [`CODE_MAX_LEN];
  logic [`CODE_LEN_W-1:0] code_len_reg, code_len_next;
  logic [7:0]            msg_mem [`MSG_LEN];
  logic [7:0]            msg_rdata_reg;
  logic                  secured_reg, secured_next;
  logic                  cal_mode_reg, cal_mode_next;
  logic                  pwr_seen_reg, pwr_seen_next;
  disp_t                 disp_reg, disp_next;
  logic [TW-1:0]         timer_reg, timer_next;
  logic                  beep_reg, beep_next;
  logic                  override_done_reg, override_done_next;
  logic                  jumper_err_reg, jumper_err_next;
  logic                  entry_err_reg, entry_err_next;
  logic                  accept_reg, accept_next, refuse_reg, refuse_next;
  logic                  rem_ack_reg, rem_ack_next, rem_err_reg, rem_err_next;
  logic                  jumper, fp_match, rem_match, rem_fmt_ok, fp_key, entry_start;
  logic [`FP_DIGITS*4-1:0] digits;
  logic [2:0]            cursor;

  assign jumper      = override_jumper || override_jumper_alt;
  assign fp_key      = cal_mode_reg && disp_reg == DISP_CODE && secure_key;
  assign entry_start = cal_mode_reg && disp_reg == DISP_BANNER && secure_key;

  // Front-panel compare: stored code must be eight long and its last six match the digits.
  always_comb begin
    fp_match = (code_len_reg == `FP_CODE_LEN);
    for (int i = 0; i < `FP_DIGITS; i++)
      if (code_mem[i + `FP_PREFIX_LEN] != (`CHAR_ZERO + {4'h0, digits[(`FP_DIGITS-1-i)*4 +: 4]}))
        fp_match = 1'b0;
  end

  // Remote compare of the whole code and format check of a new code.
  always_comb begin
    rem_match  = (rem_code_len == code_len_reg);
    rem_fmt_ok = (rem_code_len != '0) && (rem_code_len <= `CODE_LEN_W'(`CODE_MAX_LEN)) && is_letter(rem_code[7:0]);
    for (int i = 0; i < `CODE_MAX_LEN; i++) begin
      if (i < int'(rem_code_len) && rem_code[i*8 +: 8] != code_mem[i])
        rem_match = 1'b0;
      if (i > 0 && i < int'(rem_code_len) && !is_letter(rem_code[i*8 +: 8]) && !is_digit(rem_code[i*8 +: 8]))
        rem_fmt_ok = 1'b0;
    end
  end

  code_entry #(.DIGITS(`FP_DIGITS)) u_entry (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .start     (entry_start),
    .active    (cal_mode_reg && disp_reg == DISP_CODE),
    .res_left  (res_left),
    .res_right (res_right),
    .knob_up   (knob_up),
    .knob_down (knob_down),
    .digits    (digits),
    .cursor    (cursor)
  );

  cal_counter #(.WIDTH(`COUNT_W)) u_count (
    .clk          (clk),
    .srst         (srst),
    .ce           (ce),
    .factory_load (factory_load),
    .inc          (cal_param_store && cal_mode_reg && !secured_reg),
    .count        (cal_count)
  );

  // Mode, display, secure state and front-panel errors.
  always_comb begin
    cal_mode_next      = cal_mode_reg;
    pwr_seen_next      = 1'b1;
    disp_next          = disp_reg;
    timer_next         = timer_reg;
    beep_next          = 1'b0;
    secured_next       = secured_reg;
    override_done_next = override_done_reg;
    entry_err_next     = 1'b0;
    accept_next        = cal_param_store && cal_mode_reg && !secured_reg;
    refuse_next        = cal_param_store && !(cal_mode_reg && !secured_reg);
    jumper_err_next    = override_done_reg && jumper;
    if (!pwr_seen_reg && cal_key_held) begin
      cal_mode_next = 1'b1;
      beep_next     = 1'b1;
      disp_next     = secured_reg ? DISP_SECURED : DISP_BANNER;
      timer_next    = TW'(HOLD_CYCLES);
    end else if (disp_reg == DISP_SECURED || disp_reg == DISP_UNSECURED) begin
      if (timer_reg <= TW'(1))
        disp_next = DISP_BANNER;
      else
        timer_next = timer_reg - 1'b1;
    end else if (entry_start) begin
      disp_next = DISP_CODE;
    end else if (fp_key) begin
      timer_next = TW'(HOLD_CYCLES);
      if (secured_reg && (fp_match || jumper)) begin
        secured_next       = 1'b0;
        override_done_next = jumper && !fp_match;
        disp_next          = DISP_UNSECURED;
      end else if (!secured_reg && fp_match) begin
        secured_next = 1'b1;
        disp_next    = DISP_SECURED;
      end else begin
        entry_err_next = 1'b1;
        disp_next      = DISP_BANNER;
      end
    end
    if (rem_valid && rem_op == OP_UNSECURE && rem_match)
      secured_next = 1'b0;
    else if (rem_valid && rem_op == OP_SECURE && rem_match)
      secured_next = 1'b1;
    if (factory_load)
      secured_next = 1'b1;
  end

  // Mode and display state; the secure flag is storage and survives reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      cal_mode_reg      <= 1'b0;
      pwr_seen_reg      <= 1'b0;
      disp_reg          <= DISP_NORMAL;
      timer_reg         <= '0;
      beep_reg          <= 1'b0;
      override_done_reg <= 1'b0;
      entry_err_reg     <= 1'b0;
      accept_reg        <= 1'b0;
      refuse_reg        <= 1'b0;
      jumper_err_reg    <= 1'b0;
    end else if (ce) begin
      cal_mode_reg      <= cal_mode_next;
      pwr_seen_reg      <= pwr_seen_next;
      disp_reg          <= disp_next;
      timer_reg         <= timer_next;
      beep_reg          <= beep_next;
      override_done_reg <= override_done_next;
      entry_err_reg     <= entry_err_next;
      accept_reg        <= accept_next;
      refuse_reg        <= refuse_next;
      jumper_err_reg    <= jumper_err_next;
    end
  end

  // Code storage updates and remote answers.
  always_comb begin
    code_mem_next = code_mem;
    code_len_next = code_len_reg;
    rem_ack_next  = 1'b0;
    rem_err_next  = 1'b0;
    if (rem_valid && rem_op != OP_NONE) begin
      if (rem_op == OP_SET_CODE) begin
        if (rem_fmt_ok && !secured_reg) begin
          code_len_next = rem_code_len;
          for (int i = 0; i < `CODE_MAX_LEN; i++)
            code_mem_next[i] = (i < int'(rem_code_len)) ? rem_code[i*8 +: 8] : 8'h00;
        end
        rem_ack_next = rem_fmt_ok && !secured_reg;
        rem_err_next = !(rem_fmt_ok && !secured_reg);
      end else begin
        rem_ack_next = rem_match;
        rem_err_next = !rem_match;
      end
    end
    if (factory_load) begin
      code_len_next = `FP_CODE_LEN;
      for (int i = 0; i < `CODE_MAX_LEN; i++)
        code_mem_next[i] = (i < int'(`FP_CODE_LEN)) ? FACTORY[(int'(`FP_CODE_LEN)-1-i)*8 +: 8] : 8'h00;
    end
    if (rem_if_reset) begin
      rem_ack_next = 1'b0;
      rem_err_next = 1'b0;
    end
  end

  // Code, message and secure flag are storage: no reset, so power cycles keep them.
  always_ff @(posedge clk) begin
    if (ce) begin
      code_mem     <= code_mem_next;
      code_len_reg <= code_len_next;
      secured_reg  <= secured_next;
      if (rem_msg_we && int'(rem_msg_idx) < `MSG_LEN)
        msg_mem[rem_msg_idx] <= rem_msg_char;
      msg_rdata_reg <= (int'(rem_msg_ridx) < `MSG_LEN) ? msg_mem[rem_msg_ridx] : 8'h00;
    end
  end

  // Remote answer pulses.
  always_ff @(posedge clk) begin
    if (srst) begin
      rem_ack_reg <= 1'b0;
      rem_err_reg <= 1'b0;
    end else if (ce) begin
      rem_ack_reg <= rem_ack_next;
      rem_err_reg <= rem_err_next;
    end
  end

  // Outputs straight from flip-flops.
  assign cal_mode      = cal_mode_reg;
  assign secured       = secured_reg;
  assign disp          = disp_reg;
  assign beep_long     = beep_reg;
  assign entry_digits  = digits;
  assign entry_cursor  = cursor;
  assign cal_accepted  = accept_reg;
  assign cal_refused   = refuse_reg;
  assign entry_error   = entry_err_reg;
  assign jumper_error  = jumper_err_reg;
  assign rem_ack       = rem_ack_reg;
  assign rem_err       = rem_err_reg;
  assign rem_msg_rdata = msg_rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_factory_secure: assert property (ce && factory_load |=> secured_reg)
    else $error("Factory load did not secure.");
  a_refuse_secured: assert property (ce && cal_param_store && secured_reg |=> refuse_reg && !accept_reg)
    else $error("Store accepted while secured.");
  a_entry_beep: assert property ($rose(cal_mode_reg) |-> beep_reg)
    else $error("Calibration entry without long beep.");
  a_no_exit: assert property (cal_mode_reg |=> cal_mode_reg)
    else $error("Calibration mode left without power-off.");
  a_secured_notice: assert property ($rose(cal_mode_reg) && secured_reg |-> disp_reg == DISP_SECURED)
    else $error("Secured notice missing on entry.");
  a_unsecure_ok: assert property (ce && fp_key && secured_reg && fp_match && !factory_load && !rem_valid
    |=> !secured_reg && disp_reg == DISP_UNSECURED)
    else $error("Correct code did not unsecure.");
  a_resecure: assert property (ce && fp_key && !secured_reg && fp_match && !factory_load && !rem_valid
    |=> secured_reg && disp_reg == DISP_SECURED)
    else $error("Repeat sequence did not secure.");
  a_wrong_code: assert property (ce && fp_key && secured_reg && !fp_match && !jumper && !factory_load && !rem_valid
    |=> secured_reg && entry_err_reg && $stable(code_len_reg))
    else $error("Wrong code changed state.");
  a_override: assert property (ce && fp_key && secured_reg && jumper && !factory_load && !rem_valid |=> !secured_reg)
    else $error("Override did not unsecure.");
  a_jumper_err: assert property (ce && override_done_reg && jumper |=> jumper_err_reg)
    else $error("Jumper left shorted not reported.");
  a_bad_format: assert property (ce && rem_valid && rem_op == OP_SET_CODE && !rem_fmt_ok && !rem_if_reset
    |=> rem_err_reg ##0 $stable(code_len_reg))
    else $error("Malformed code accepted.");
  a_notice_ends: assert property (ce && disp_reg == DISP_UNSECURED && timer_reg == TW'(1) |=> disp_reg == DISP_BANNER)
    else $error("Notice did not return to banner.");

  c_entry: cover property ($rose(cal_mode_reg));
  c_unsecure: cover property (disp_reg == DISP_UNSECURED);
  c_override: cover property ($rose(override_done_reg));
  c_accept: cover property (accept_reg);
endmodule : calibration_lock_and_counter

// ===== tb/host_model.sv
// Remote host model: one command strobe per call, fields held through the sampling edge.
// Assumes the lock takes the strobe on the rising clk edge.
`timescale 1ns/1ns
`include "cal_lock_consts.svh"
module host_model (
  input  wire logic                  clk,         // System clock.
  output logic                       rem_valid,   // Command strobe.
  output cal_lock_pkg::rem_op_t      rem_op,      // Command.
  output logic [`CODE_MAX_LEN*8-1:0] rem_code,    // Code, character 0 low.
  output logic [`CODE_LEN_W-1:0]     rem_code_len // Code length.
);
  import cal_lock_pkg::*;
  // Idle values at time zero.
  initial begin
    rem_valid = 1'b0;
    rem_op = OP_NONE;
    rem_code = '0;
    rem_code_len = 4'h0;
  end
  // Sends a code of the given length; the released code is inverted so stale values never match.
  task automatic send(input rem_op_t op, input string s, input logic [3:0] len);
    @(negedge clk);
    rem_op = op;
    rem_code_len = len;
    for (int i = 0; i < s.len(); i++) rem_code[8*i+:8] = s[i];
    rem_valid = 1'b1;
    @(negedge clk);
    rem_valid = 1'b0;
    rem_code = ~rem_code;
  endtask : send
endmodule : host_model

// ===== tb/calibration_lock_and_counter_tb_top.sv
// Self-checking bench for the calibration lock: remote table, front-panel entry, counter wrap.
// Assumes HOLD_CYCLES of 8 and a 4 ns clock.
`timescale 1ns/1ns
module calibration_lock_and_counter_tb_top;
  import cal_lock_pkg::*;
  typedef struct {rem_op_t op; string s; logic [3:0] len; logic err; logic sec;} row_t;
  logic clk = 0, srst = 1, fl = 1, ck = 1, sk = 0, rl = 0, rr = 0, ku = 0, kd = 0, st = 0;
  logic jp = 0, ja = 0, mw = 0, rif = 0, bp, ac, je;
  logic cal_mode, secured, rem_valid, rem_ack, rem_err, entry_error, cal_refused;
  logic [4:0] seen;
  logic [7:0] md;
  logic [2:0] ec;
  logic [23:0] ed;
  rem_op_t rem_op;
  disp_t disp;
  logic [95:0] rem_code;
  logic [3:0] rem_code_len;
  logic [14:0] cal_count;
  int errors = 0, compares = 0;
  row_t rows[10] = '{'{OP_UNSECURE, "XY000001", 8, 0, 0}, '{OP_SET_CODE, "A", 0, 1, 0},
    '{OP_SET_CODE, "A", 13, 1, 0}, '{OP_SET_CODE, "9B", 2, 1, 0}, '{OP_SET_CODE, "AB123456", 8, 0, 0},
    '{OP_SECURE, "AB123456", 8, 0, 1}, '{OP_UNSECURE, "XY000001", 8, 1, 1},
    '{OP_UNSECURE, "AB123456", 8, 0, 0}, '{OP_SET_CODE, "XY000001", 8, 0, 0}, '{OP_SECURE, "XY000001", 8, 0, 1}};
  always #2 clk = ~clk;
  // Sticky capture of answer pulses: accepted, ack, err, entry error, refused.
  always @(posedge clk) seen <= seen | {ac, rem_ack, rem_err, entry_error, cal_refused};
  host_model host (.clk(clk), .rem_valid(rem_valid), .rem_op(rem_op), .rem_code(rem_code), .rem_code_len(rem_code_len));
  calibration_lock_and_counter #(.HOLD_CYCLES(8)) DUT (.clk(clk), .srst(srst), .ce(1'b1), .factory_load(fl),
    .cal_key_held(ck), .secure_key(sk), .res_left(rl), .res_right(rr), .knob_up(ku), .knob_down(kd),
    .override_jumper(jp), .override_jumper_alt(ja), .cal_param_store(st), .rem_if_reset(rif), .rem_valid(rem_valid),
    .rem_op(rem_op), .rem_code(rem_code), .rem_code_len(rem_code_len), .rem_msg_we(mw), .rem_msg_idx(6'h27),
    .rem_msg_char(8'h4D), .rem_msg_ridx(6'h27), .cal_mode(cal_mode), .secured(secured), .disp(disp), .beep_long(bp),
    .entry_digits(ed), .entry_cursor(ec), .cal_count(cal_count), .cal_accepted(ac), .cal_refused(cal_refused),
    .entry_error(entry_error), .jumper_error(je), .rem_ack(rem_ack), .rem_err(rem_err), .rem_msg_rdata(md));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Raises a key for n cycles, then lets the answer settle.
  task automatic hold(ref logic s, input int n);
    @(negedge clk);
    seen = '0;
    s = 1'b1;
    repeat (n) @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask : hold
  task automatic finish_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Watchdog against a hang.
  initial begin
    #400000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(negedge clk);
    srst = 0;
    fl = 0;
    @(negedge clk);
    chk({cal_mode, secured, disp, bp}, {2'b11, DISP_SECURED, 1'b1});
    repeat (10) @(negedge clk);
    chk(disp, DISP_BANNER);
    hold(st, 1);
    chk({seen[0], cal_count}, 16'h8000);
    foreach (rows[i]) begin
      seen = '0;
      host.send(rows[i].op, rows[i].s, rows[i].len);
      repeat (2) @(negedge clk);
      chk({seen[3:2], secured}, {~rows[i].err, rows[i].err, rows[i].sec});
    end
    hold(sk, 1);
    hold(sk, 1);
    chk({seen[1], secured}, 2'b11);
    hold(sk, 1);
    repeat (5) hold(rr, 1);
    hold(ku, 1);
    chk({ec, ed}, {3'h5, 24'h000001});
    hold(sk, 1);
    chk({secured, disp}, {1'b0, DISP_UNSECURED});
    hold(st, 5);
    chk({seen[4], cal_count}, 16'h8005);
    hold(st, 32762);
    chk(cal_count, 15'h7FFF);
    hold(st, 1);
    chk({cal_mode, cal_count}, 16'h8000);
    // Message write at the last index, then a secure command whose answer is hidden by a remote interface reset.
    hold(st, 2);
    hold(mw, 1);
    chk({cal_count, md}, {15'h0002, 8'h4D});
    rif = 1;
    seen = '0;
    host.send(OP_SECURE, "XY000001", 8);
    rif = 0;
    repeat (2) @(negedge clk);
    chk({seen[3:2], secured}, 3'b001);
    // Power cycle in mid-run: storage survives, calibration mode is entered again.
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    @(negedge clk);
    chk({cal_mode, secured, disp, bp, cal_count, md}, {2'b11, DISP_SECURED, 1'b1, 15'h0002, 8'h4D});
    repeat (10) @(negedge clk);
    // Override with a wrong code, then either jumper keeps the error up.
    jp = 1;
    hold(sk, 1);
    hold(sk, 1);
    chk({secured, disp, je}, {1'b0, DISP_UNSECURED, 1'b1});
    jp = 0;
    ja = 1;
    @(negedge clk);
    chk(je, 1'b1);
    ja = 0;
    @(negedge clk);
    chk(je, 1'b0);
    // Front-panel re-secure with every cursor and knob key.
    repeat (4) @(negedge clk);
    hold(sk, 1);
    repeat (6) hold(rr, 1);
    hold(rl, 1);
    hold(rr, 1);
    hold(kd, 1);
    hold(ku, 1);
    hold(ku, 1);
    hold(sk, 1);
    chk({secured, disp, ed}, {1'b1, DISP_SECURED, 24'h000001});
    // Power-up without the calibrate key: no calibration mode, stores refused.
    ck = 0;
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    hold(st, 1);
    chk({cal_mode, disp, seen[0], cal_count}, {1'b0, DISP_NORMAL, 1'b1, 15'h0002});
    finish_test();
  end
endmodule : calibration_lock_and_counter_tb_top
